/* File: pkg/sacc_pkg.sv */
// Constants, register map and types of the scaling accumulator.
// Assumes one clock; all users import the whole package.
package sacc_pkg;

    localparam int SACC_REG_AW = 4;
    localparam int SACC_REG_DW = 32;

    localparam logic [3:0] SACC_REG_CTRL   = 4'h0;
    localparam logic [3:0] SACC_REG_STATUS = 4'h1;
    localparam logic [3:0] SACC_REG_RESULT = 4'h2;
    localparam logic [3:0] SACC_REG_CONFIG = 4'h3;
    localparam logic [3:0] SACC_REG_RATE   = 4'h4;
    localparam logic [3:0] SACC_REG_COUNT  = 4'h5;
    localparam logic [3:0] SACC_REG_SAMPLE = 4'h6;

    localparam int SACC_CTRL_RUN_BIT   = 0;
    localparam int SACC_CTRL_CLR_BIT   = 1;
    localparam int SACC_STAT_WRAP_BIT  = 0;
    localparam int SACC_STAT_RST_BIT   = 1;
    localparam int SACC_STAT_HOLD_BIT  = 2;

    localparam int SACC_CFG_FRAC_POS   = 8;
    localparam int SACC_CFG_SGN_POS    = 16;
    localparam int SACC_CFG_SUB_POS    = 17;
    localparam int SACC_CFG_RLD_POS    = 18;
    localparam int SACC_CFG_RST_POS    = 19;
    localparam int SACC_CFG_SCALE_POS  = 20;
    localparam int SACC_CFG_GROW_POS   = 24;

    localparam logic        SACC_RUN_RESET  = 1'b1;
    localparam logic [7:0]  SACC_RATE_RESET = 8'h00;
    localparam logic [7:0]  SACC_FP_MSB_GROWTH_MAX = 8'h36;

    typedef enum logic [3:0] {
        SACC_SCALE_1   = 4'h0,
        SACC_SCALE_2   = 4'h1,
        SACC_SCALE_4   = 4'h2,
        SACC_SCALE_8   = 4'h3,
        SACC_SCALE_16  = 4'h4,
        SACC_SCALE_32  = 4'h5,
        SACC_SCALE_64  = 4'h6,
        SACC_SCALE_128 = 4'h7,
        SACC_SCALE_256 = 4'h8
    } sacc_scale_type;

    typedef enum logic {
        SACC_OP_ADD = 1'b0,
        SACC_OP_SUB = 1'b1
    } sacc_op_type;

    typedef enum logic [1:0] {
        SACC_ACT_HOLD  = 2'h0,
        SACC_ACT_ACCUM = 2'h1,
        SACC_ACT_ZERO  = 2'h2,
        SACC_ACT_LOAD  = 2'h3
    } sacc_act_type;

endpackage : sacc_pkg

/* File: pkg/sacc_dp_if.sv */
// Operand and result bundle between the core and its arithmetic unit.
// Assumes the arithmetic side is purely combinational.
`timescale 1ns/100ps
interface sacc_dp_if
    import sacc_pkg::*;
#(
    parameter int DATA_W = 16
);
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] sample;
    sacc_op_type       op;
    sacc_scale_type    scale;
    logic [DATA_W-1:0] result;
    logic              wrap;

    modport core  (output acc, sample, op, scale, input result, wrap);
    modport arith (input acc, sample, op, scale, output result, wrap);
endinterface : sacc_dp_if

/* File: src/sacc_scale_add.sv */
// Scale-by-shift and add/subtract of the accumulator feedback path.
// Assumes the accumulator operand comes from a register and the sample from the live input; the result is combinational.
`timescale 1ns/100ps
module sacc_scale_add
    import sacc_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter bit SIGNED = 1'b1
) (
    sacc_dp_if.arith dp
);
    logic signed [DATA_W-1:0] scaled_s;
    logic        [DATA_W-1:0] scaled;
    logic        [DATA_W:0]   ext_a;
    logic        [DATA_W:0]   ext_b;
    logic        [DATA_W:0]   full;

    always_comb begin
        scaled_s = $signed(dp.acc) >>> dp.scale;
        scaled   = SIGNED ? scaled_s : (dp.acc >> dp.scale);
        ext_a    = {SIGNED & scaled[DATA_W-1], scaled};
        ext_b    = {SIGNED & dp.sample[DATA_W-1], dp.sample};
        if (dp.op == SACC_OP_SUB) begin
            full = ext_a - ext_b;
        end else begin
            full = ext_a + ext_b;
        end
        // Top bit dropped on purpose: plain two's complement wrap
        dp.result = full[DATA_W-1:0];
        dp.wrap   = SIGNED ? (full[DATA_W] ^ full[DATA_W-1]) : full[DATA_W];
    end
endmodule : sacc_scale_add

/* File: src/sacc_rate_div.sv */
// Clock enable divider: one tick every div_in+1 cycles.
// Assumes div_in is quasi-static; a change does not restart the count, which runs on against the new value.
`timescale 1ns/100ps
module sacc_rate_div
    import sacc_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic             sys_clk_in,
    input  wire logic             nrst_in,
    input  wire logic [CNT_W-1:0] div_in,
    output logic                  tick_out
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } sacc_div_type;

    sacc_div_type st_q;
    sacc_div_type st_d;

    always_comb begin
        st_d = st_q;
        if (st_q.cnt >= div_in) begin
            st_d.cnt  = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt  = st_q.cnt + 1'b1;
            st_d.tick = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_out = st_q.tick;
endmodule : sacc_rate_div

/* File: src/sacc_top.sv */
// Scaling accumulator core with a small register port.
// Assumes sample, enable and reset are synchronous to sys_clk_in and
// that a register read returns data in the following cycle only.
`timescale 1ns/100ps
module sacc_top
    import sacc_pkg::*;
#(
    parameter int             DATA_W    = 16,
    parameter int             FRAC_BITS = 0,
    parameter bit             SIGNED    = 1'b1,
    parameter sacc_op_type    OPERATION = SACC_OP_ADD,
    parameter sacc_scale_type FB_SCALE  = SACC_SCALE_1,
    parameter bit             HAS_RST   = 1'b1,
    parameter bit             RELOAD    = 1'b0,
    parameter bit             MULTIRATE = 1'b0,
    parameter int             CNT_W     = 16
) (
    input  wire logic                   sys_clk_in,
    input  wire logic                   nrst_in,
    input  wire logic [DATA_W-1:0]      sample_in,
    input  wire logic                   acc_en_in,
    input  wire logic                   acc_rst_in,
    input  wire logic [SACC_REG_AW-1:0] reg_addr_in,
    input  wire logic [SACC_REG_DW-1:0] reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic      [SACC_REG_DW-1:0] reg_rdata_out,
    output logic      [DATA_W-1:0]      acc_out
);
    // Reload only exists when a reset port is built
    localparam bit RELOAD_EFF = HAS_RST & RELOAD;

    typedef struct packed {
        logic [DATA_W-1:0]      acc;
        logic [DATA_W-1:0]      last;
        logic [SACC_REG_DW-1:0] rdata;
        logic [CNT_W-1:0]       count;
        logic [7:0]             rate;
        logic                   run;
        logic                   clr_pend;
        logic                   wrap_flag;
        logic                   rst_seen;
        logic                   held;
    } sacc_state_type;

    sacc_state_type st_q;
    sacc_state_type st_d;

    sacc_dp_if #(.DATA_W(DATA_W)) dp ();

    logic         rate_tick;
    logic         ce;
    logic         rst_req;
    sacc_act_type act;
    logic [SACC_REG_DW-1:0] rd_word;
    logic [SACC_REG_DW-1:0] cfg_word;

    sacc_scale_add #(
        .DATA_W (DATA_W),
        .SIGNED (SIGNED)
    ) u_arith (
        .dp (dp.arith)
    );

    sacc_rate_div #(
        .CNT_W (8)
    ) u_div (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .div_in     (st_q.rate),
        .tick_out   (rate_tick)
    );

    // Datapath width follows the sample, so the result matches it
    function automatic logic [SACC_REG_DW-1:0] to_word(
        input logic [DATA_W-1:0] v
    );
        logic [SACC_REG_DW-1:0] w;
        w = '0;
        for (int i = 0; i < SACC_REG_DW; i++) begin
            if (i < DATA_W) begin
                w[i] = v[i];
            end else begin
                w[i] = SIGNED & v[DATA_W-1];
            end
        end
        return w;
    endfunction : to_word

    function automatic logic [7:0] to_byte(input int v);
        return v[7:0];
    endfunction : to_byte

    assign dp.acc    = st_q.acc;
    // The live sample feeds the adder so a result lags its sample by one
    assign dp.sample = sample_in;
    assign dp.op     = OPERATION;
    assign dp.scale  = FB_SCALE;

    // Read-only build description; the float growth limit is reported too
    always_comb begin
        cfg_word = '0;
        cfg_word[7:0] = to_byte(DATA_W);
        cfg_word[SACC_CFG_FRAC_POS +: 8] = to_byte(FRAC_BITS);
        cfg_word[SACC_CFG_SGN_POS] = SIGNED;
        cfg_word[SACC_CFG_SUB_POS] = (OPERATION == SACC_OP_SUB);
        cfg_word[SACC_CFG_RLD_POS] = RELOAD_EFF;
        cfg_word[SACC_CFG_RST_POS] = HAS_RST;
        cfg_word[SACC_CFG_SCALE_POS +: 4] = FB_SCALE;
        cfg_word[SACC_CFG_GROW_POS +: 8] = SACC_FP_MSB_GROWTH_MAX;
    end

    always_comb begin
        rd_word = '0;
        unique case (reg_addr_in)
            SACC_REG_CTRL: begin
                rd_word[SACC_CTRL_RUN_BIT] = st_q.run;
            end
            SACC_REG_STATUS: begin
                rd_word[SACC_STAT_WRAP_BIT] = st_q.wrap_flag;
                rd_word[SACC_STAT_RST_BIT]  = st_q.rst_seen;
                rd_word[SACC_STAT_HOLD_BIT] = st_q.held;
            end
            SACC_REG_RESULT: begin
                rd_word = to_word(st_q.acc);
            end
            SACC_REG_CONFIG: begin
                rd_word = cfg_word;
            end
            SACC_REG_RATE: begin
                rd_word[7:0] = st_q.rate;
            end
            SACC_REG_COUNT: begin
                rd_word = SACC_REG_DW'(st_q.count);
            end
            SACC_REG_SAMPLE: begin
                rd_word = to_word(st_q.last);
            end
            default: begin
                // Unmapped offsets read as zero
                rd_word = '0;
            end
        endcase
    end

    // Enable is the external enable gated by software run and rate tick
    always_comb begin
        ce      = acc_en_in & st_q.run & rate_tick;
        rst_req = (HAS_RST & acc_rst_in) | st_q.clr_pend;
        if (rst_req) begin
            if (!RELOAD_EFF) begin
                act = SACC_ACT_ZERO;
            end else if (MULTIRATE && !rate_tick) begin
                // Reload is tied to the rate tick, so it waits for it
                act = SACC_ACT_HOLD;
            end else begin
                act = SACC_ACT_LOAD;
            end
        end else if (ce) begin
            act = SACC_ACT_ACCUM;
        end else begin
            act = SACC_ACT_HOLD;
        end
    end

    always_comb begin
        st_d       = st_q;
        st_d.rdata = '0;
        if (reg_rd_in) begin
            st_d.rdata = rd_word;
        end

        unique case (act)
            SACC_ACT_HOLD: begin
                st_d.held = 1'b1;
            end
            SACC_ACT_ACCUM: begin
                st_d.acc   = dp.result;
                st_d.last  = sample_in;
                st_d.count = st_q.count + 1'b1;
                st_d.held  = 1'b0;
            end
            SACC_ACT_ZERO: begin
                st_d.acc   = '0;
                st_d.last  = '0;
                st_d.count = '0;
                st_d.held  = 1'b0;
            end
            SACC_ACT_LOAD: begin
                st_d.acc   = sample_in;
                st_d.last  = '0;
                st_d.count = '0;
                st_d.held  = 1'b0;
            end
        endcase

        // A soft clear is consumed once its reset action has happened
        if (act == SACC_ACT_ZERO || act == SACC_ACT_LOAD) begin
            st_d.clr_pend = 1'b0;
            st_d.rst_seen = 1'b1;
        end

        if (reg_wr_in) begin
            unique case (reg_addr_in)
                SACC_REG_CTRL: begin
                    st_d.run = reg_wdata_in[SACC_CTRL_RUN_BIT];
                    if (reg_wdata_in[SACC_CTRL_CLR_BIT]) begin
                        st_d.clr_pend = 1'b1;
                    end
                end
                SACC_REG_STATUS: begin
                    if (reg_wdata_in[SACC_STAT_WRAP_BIT]) begin
                        st_d.wrap_flag = 1'b0;
                    end
                    if (reg_wdata_in[SACC_STAT_RST_BIT]) begin
                        st_d.rst_seen = 1'b0;
                    end
                end
                SACC_REG_RATE: begin
                    st_d.rate = reg_wdata_in[7:0];
                end
                default: begin
                    // Writes to read-only or unmapped offsets are dropped
                    st_d.rate = st_d.rate;
                end
            endcase
        end

        // Hardware set wins over a same-cycle software clear
        if (act == SACC_ACT_ACCUM && dp.wrap) begin
            st_d.wrap_flag = 1'b1;
        end
        if (act == SACC_ACT_ZERO || act == SACC_ACT_LOAD) begin
            st_d.rst_seen = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            st_q          <= '0;
            st_q.run      <= SACC_RUN_RESET;
            st_q.rate     <= SACC_RATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign acc_out       = st_q.acc;
    assign reg_rdata_out = st_q.rdata;

endmodule : sacc_top

/* File: testbench/sacc_top_properties.sv */
// Port checker of the scaling accumulator top.
// Assumes it is bound to sacc_top and sees only its ports.
`timescale 1ns/100ps
module sacc_top_properties
    import sacc_pkg::*;
#(
    parameter int             DATA_W    = 16,
    parameter bit             SIGNED    = 1'b1,
    parameter sacc_op_type    OPERATION = SACC_OP_ADD,
    parameter sacc_scale_type FB_SCALE  = SACC_SCALE_1,
    parameter bit             HAS_RST   = 1'b1,
    parameter bit             RELOAD    = 1'b0,
    parameter bit             MULTIRATE = 1'b0
) (
    input wire logic                   sys_clk_in,
    input wire logic                   nrst_in,
    input wire logic [DATA_W-1:0]      sample_in,
    input wire logic                   acc_en_in,
    input wire logic                   acc_rst_in,
    input wire logic [SACC_REG_AW-1:0] reg_addr_in,
    input wire logic [SACC_REG_DW-1:0] reg_wdata_in,
    input wire logic                   reg_wr_in,
    input wire logic                   reg_rd_in,
    input wire logic [SACC_REG_DW-1:0] reg_rdata_out,
    input wire logic [DATA_W-1:0]      acc_out
);
    logic       run_q;
    logic       slow_q;
    logic       quiet_q;
    logic [1:0] age_q;
    logic       go;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    function automatic logic [DATA_W-1:0] nx(logic [DATA_W-1:0] a, b);
        logic [DATA_W-1:0] s;
        if (SIGNED)
            s = $signed(a) >>> FB_SCALE;
        else
            s = a >> FB_SCALE;
        return (OPERATION == SACC_OP_SUB) ? s - b : s + b;
    endfunction : nx

    function automatic logic [31:0] ext(logic [DATA_W-1:0] a);
        return {{(32-DATA_W){SIGNED & a[DATA_W-1]}}, a};
    endfunction : ext

    // Step timing is only trusted while software has not slowed the core
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            run_q   <= 1'b1;
            slow_q  <= 1'b0;
            quiet_q <= 1'b0;
            age_q   <= 2'h0;
        end else begin
            quiet_q <= !reg_wr_in;
            age_q   <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
            if (reg_wr_in && reg_addr_in == SACC_REG_CTRL)
                run_q <= reg_wdata_in[SACC_CTRL_RUN_BIT];
            if (reg_wr_in && reg_addr_in == SACC_REG_RATE)
                slow_q <= |reg_wdata_in[7:0];
        end
    end

    assign go = acc_en_in & !acc_rst_in & run_q & !slow_q & quiet_q
              & (age_q == 2'h3);

    a_reset_result: assert property (
        $rose(nrst_in) |-> acc_out == '0) else $error("result not cleared");
    a_hold_value: assert property (
        !acc_en_in && !acc_rst_in && quiet_q |=> $stable(acc_out))
        else $error("result moved while disabled");
    a_clear_zero: assert property (
        HAS_RST && !RELOAD && acc_rst_in |=> acc_out == '0)
        else $error("reset did not zero");
    a_reload_sample: assert property (
        HAS_RST && RELOAD && !MULTIRATE && acc_rst_in
        |=> acc_out == $past(sample_in)) else $error("reload wrong");
    a_reset_wins: assert property (
        HAS_RST && !MULTIRATE && acc_rst_in && acc_en_in
        |=> acc_out == (RELOAD ? $past(sample_in) : '0))
        else $error("enable beat reset");
    a_accum_step: assert property (
        go |=> acc_out == nx($past(acc_out), $past(sample_in)))
        else $error("accumulate step wrong");
    a_read_idle: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == '0)
        else $error("read data outside its cycle");
    a_result_read: assert property (
        reg_rd_in && reg_addr_in == SACC_REG_RESULT
        |=> reg_rdata_out == ext($past(acc_out))) else $error("result read");
    a_config_read: assert property (
        reg_rd_in && reg_addr_in == SACC_REG_CONFIG
        |=> reg_rdata_out[31:24] == SACC_FP_MSB_GROWTH_MAX
            && reg_rdata_out[7:0] == 8'(DATA_W)) else $error("config read");

    c_accum: cover property (go ##1 go);
    c_reset: cover property (acc_rst_in && acc_en_in);
    c_hold:  cover property (!acc_en_in && !acc_rst_in && quiet_q);
endmodule : sacc_top_properties

/* File: testbench/sacc_src_model.sv */
// Upstream datapath model: offers a sample with its enable, may stall.
// Assumes the bench drives it right after rising edges.
`timescale 1ns/100ps
module sacc_src_model #(
    parameter int DATA_W = 16
) (
    input  wire logic [DATA_W-1:0] val_in,
    input  wire logic              vld_in,
    input  wire logic              rst_in,
    input  wire logic              stall_in,
    output logic      [DATA_W-1:0] sample_out,
    output logic                   en_out
);
    // An idle or stalled source shows junk unless rst_in is high, so the core must not use it
    always_comb begin
        en_out     = vld_in & ~stall_in;
        sample_out = (en_out | rst_in) ? val_in : ~val_in;
    end
endmodule : sacc_src_model

/* File: testbench/tb_top.sv */
// Self-checking bench: an adding and a subtracting build side by side.
// Assumes the source model and the port checker are compiled first.
`timescale 1ns/100ps
module tb_top;
    import sacc_pkg::*;
    logic        clk, nrst, vld, rst, stall, en, wr, rd_s, run_m;
    logic [15:0] val, smp, acc_a, acc_b, ea, eb;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata_a, rdata_b;
    int          errors, num_checks;

    sacc_src_model #(.DATA_W(16)) src_u (.val_in(val), .vld_in(vld),
        .rst_in(rst), .stall_in(stall), .sample_out(smp), .en_out(en));
    sacc_top dut_u (.sys_clk_in(clk), .nrst_in(nrst), .sample_in(smp),
        .acc_en_in(en), .acc_rst_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd_s),
        .reg_rdata_out(rdata_a), .acc_out(acc_a));
    sacc_top #(.OPERATION(SACC_OP_SUB), .FB_SCALE(SACC_SCALE_4),
        .RELOAD(1'b1)) dut_s (.sys_clk_in(clk), .nrst_in(nrst),
        .sample_in(smp), .acc_en_in(en), .acc_rst_in(rst),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd_s), .reg_rdata_out(rdata_b), .acc_out(acc_b));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    // Checks the edge of the previous step, then models this one
    task automatic step(input logic [15:0] s, input logic e, r,
                        input logic st = 1'b0);
        logic signed [15:0] sh;
        @(posedge clk);
        val   <= s;
        vld   <= e;
        rst   <= r;
        stall <= st;
        @(negedge clk);
        chk({16'h0, acc_a}, {16'h0, ea});
        chk({16'h0, acc_b}, {16'h0, eb});
        sh = $signed(eb) >>> 2;
        if (r) begin
            ea = '0;
            eb = s;
        end else if (e && !st && run_m) begin
            ea = ea + s;
            eb = sh - s;
        end
    endtask : step

    task automatic rd(input logic [3:0] a, input logic [31:0] xa, xb);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk(rdata_a, xa);
        chk(rdata_b, xb);
    endtask : rd

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic t_accum;
        logic [15:0] v [5] = '{16'h7000, 16'h7000, 16'h8123, 16'h0005, 16'hfff0};
        foreach (v[i]) step(v[i], 1'b1, 1'b0);
        $display("accumulate done");
    endtask : t_accum

    task automatic t_hold;
        step(16'h1111, 1'b1, 1'b0, 1'b1);
        step(16'h2222, 1'b0, 1'b0);
        step(16'h0abc, 1'b1, 1'b0);
        step(16'h0def, 1'b1, 1'b0);
        $display("hold done");
    endtask : t_hold

    task automatic t_reset;
        step(16'h9abc, 1'b1, 1'b1);
        step(16'h4321, 1'b0, 1'b1);
        step(16'h0001, 1'b1, 1'b0);
        step(16'h0002, 1'b1, 1'b0);
        step(16'h0003, 1'b1, 1'b0);
        step(16'h0000, 1'b0, 1'b0);
        step(16'h0000, 1'b0, 1'b0);
        $display("reset done");
    endtask : t_reset

    task automatic t_regs;
        rd(SACC_REG_RESULT, {{16{ea[15]}}, ea}, {{16{eb[15]}}, eb});
        rd(SACC_REG_CONFIG, 32'h3609_0010, 32'h362f_0010);
        wr_reg(SACC_REG_RESULT, 32'h0000_5555);
        rd(SACC_REG_RESULT, {{16{ea[15]}}, ea}, {{16{eb[15]}}, eb});
        rd(4'hf, 32'h0, 32'h0);
        step(16'h0000, 1'b0, 1'b0);
        $display("registers done");
    endtask : t_regs

    // Software stop and soft clear, then the status, count and rate views
    task automatic t_ctrl;
        wr_reg(SACC_REG_CTRL, 32'h0);
        run_m = 1'b0;
        step(16'h1234, 1'b1, 1'b0);
        step(16'h1234, 1'b1, 1'b0);
        wr_reg(SACC_REG_CTRL, 32'h3);
        run_m = 1'b1;
        ea    = '0;
        eb    = 16'h1234;
        step(16'h0007, 1'b1, 1'b0);
        step(16'h0000, 1'b0, 1'b0);
        rd(SACC_REG_STATUS, 32'h7, 32'h7);
        wr_reg(SACC_REG_STATUS, 32'h3);
        rd(SACC_REG_STATUS, 32'h4, 32'h4);
        rd(SACC_REG_COUNT, 32'h1, 32'h1);
        rd(SACC_REG_SAMPLE, 32'h7, 32'h7);
        wr_reg(SACC_REG_RATE, 32'h3);
        rd(SACC_REG_RATE, 32'h3, 32'h3);
        wr_reg(SACC_REG_RATE, 32'h0);
        rd(SACC_REG_CTRL, 32'h1, 32'h1);
        step(16'h0000, 1'b0, 1'b0);
        $display("control done");
    endtask : t_ctrl

    initial begin
        nrst = 1'b0;
        {val, vld, rst, stall, addr, wdata, wr, rd_s} = '0;
        {ea, eb} = '0;
        run_m = 1'b1;
        errors = 0;
        num_checks = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_accum;
        t_hold;
        t_reset;
        t_regs;
        t_ctrl;
        stop_test;
    end

    // About 62 cycles are needed; allow several times that
    initial begin
        #20000;
        errors++;
        stop_test;
    end
endmodule : tb_top

bind sacc_top sacc_top_properties #(.DATA_W(DATA_W), .SIGNED(SIGNED),
    .OPERATION(OPERATION), .FB_SCALE(FB_SCALE), .HAS_RST(HAS_RST),
    .RELOAD(RELOAD), .MULTIRATE(MULTIRATE)) chk_u (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .sample_in(sample_in),
    .acc_en_in(acc_en_in), .acc_rst_in(acc_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .acc_out(acc_out));
